// ### src/aamc_pkg.sv
/*
  shared constants of the auto mute controller: register offsets, field
  positions, reset values and the zero-run lengths in frames.
  assumes one frame_tick per received stereo frame.
*/
package aamc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ZERO_RUN_TIME_SELECT      = 8'h3B;
  localparam logic [7:0] ADDR_MUTE_COUPLING_AND_ENABLES = 8'h41;
  localparam logic [7:0] ADDR_ANALOG_MUTE_WAIT          = 8'h42;

  localparam logic [7:0] RST_ZERO_RUN_TIME_SELECT       = 8'h00;
  localparam logic [7:0] RST_MUTE_COUPLING_AND_ENABLES  = 8'h04;
  localparam logic [7:0] RST_ANALOG_MUTE_WAIT           = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LEFT_TIME_LSB        = 4;
  localparam int RIGHT_TIME_LSB       = 0;
  localparam int TIME_W               = 3;
  localparam int COUPLING_BIT         = 2;
  localparam int ENABLE_RIGHT_BIT     = 1;
  localparam int ENABLE_LEFT_BIT      = 0;

  localparam logic [7:0] ZERO_RUN_TIME_MASK = 8'h77;
  localparam logic [7:0] COUPLING_MASK      = 8'h07;

  // ----------------------------------------------------------------
  // zero-run lengths, frames at 48 kHz
  // ----------------------------------------------------------------
  localparam int SAMPLE_RATE_HZ = 48000;
  localparam int RUN_W          = 19;

  localparam logic [18:0] RUN_21MS   = 19'h00400;
  localparam logic [18:0] RUN_106MS  = 19'h01400;
  localparam logic [18:0] RUN_213MS  = 19'h02800;
  localparam logic [18:0] RUN_533MS  = 19'h06400;
  localparam logic [18:0] RUN_1S07   = 19'h0C800;
  localparam logic [18:0] RUN_2S13   = 19'h19000;
  localparam logic [18:0] RUN_5S33   = 19'h3E800;
  localparam logic [18:0] RUN_10S66  = 19'h7D000;

  // fixed frame counts, so the times scale with the incoming rate
  function automatic logic [18:0] aamc_run_limit(input logic [2:0] sel);
    logic [18:0] lim;
    lim = RUN_21MS;
    case (sel)
      3'h0:    lim = RUN_21MS;
      3'h1:    lim = RUN_106MS;
      3'h2:    lim = RUN_213MS;
      3'h3:    lim = RUN_533MS;
      3'h4:    lim = RUN_1S07;
      3'h5:    lim = RUN_2S13;
      3'h6:    lim = RUN_5S33;
      default: lim = RUN_10S66;
    endcase
    return lim;
  endfunction

endpackage

// ### src/aamc_chan.sv
/*
  one audio channel: zero-run counter, digital mute flag and the
  frame-counted wait before analog mute.
  assumes frame_tick and sample come from logic on clk_sys.
*/
`timescale 1ns/10ps
module aamc_chan #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic                frame_tick,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic [2:0]          time_sel,
  input  wire logic                mute_req,
  input  wire logic [7:0]          wait_count,
  output logic                     zero_met,
  output logic                     muted_q,
  output logic                     analog_mute_q
);

  // ----------------------------------------------------------------
  // zero-run counter
  // ----------------------------------------------------------------
  logic [aamc_pkg::RUN_W-1:0] run_q;
  logic [aamc_pkg::RUN_W-1:0] limit;
  logic [7:0]                 wait_q;

  localparam logic [aamc_pkg::RUN_W-1:0] RUN_STEP =
    {{(aamc_pkg::RUN_W-1){1'b0}}, 1'b1};

  assign limit    = aamc_pkg::aamc_run_limit(time_sel);
  // a shortened time takes effect at once through the compare
  assign zero_met = (run_q >= limit);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_q <= '0;
    end else if (frame_tick) begin
      if (sample != '0) begin
        run_q <= '0;
      end else if (run_q < limit) begin
        run_q <= run_q + RUN_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // digital mute flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      muted_q <= 1'b0;
    end else begin
      muted_q <= mute_req;
    end
  end

  // ----------------------------------------------------------------
  // analog mute wait
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 8'h00;
    end else if (!muted_q) begin
      wait_q <= 8'h00;
    end else if (frame_tick && (wait_q < wait_count)) begin
      wait_q <= wait_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      analog_mute_q <= 1'b0;
    end else begin
      analog_mute_q <= muted_q && (wait_q >= wait_count);
    end
  end

endmodule // aamc_chan

// ### src/aamc_top.sv
/*
  auto mute controller: per-channel zero detection, coupled or
  independent muting, and a delayed analog mute, with three host
  registers on a simple address/strobe port.
  assumes samples, frame_tick and register strobes are on clk_sys.
*/
// What this block does
// - the left channel mutes only after a zero run chosen by a 3-bit code.
// - the right channel uses the same 3-bit zero run coding on its own.
// - zero run times are fixed frame counts, exact at 48 kHz only.
// - with coupling clear each channel mutes on its own zero run.
// - with coupling set, the reset value, both mute only when both qualify.
// - bit 1 of the coupling register enables right channel auto mute.
// - bit 0 of the coupling register enables left channel auto mute.
// - coupled, the left never mutes while the right enable is clear.
// - coupled, the right never mutes while the left enable is clear.
// - analog mute follows digital mute after 0 to 255 frame periods.
// - the wait lets the last unmuted samples leave the analog path.
`timescale 1ns/10ps
module aamc_top #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic                frame_tick,
  input  wire logic [SAMPLE_W-1:0] sample_left,
  input  wire logic [SAMPLE_W-1:0] sample_right,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_we,
  input  wire logic                reg_re,
  output logic      [7:0]          reg_rdata_q,
  output logic                     reg_rvalid_q,
  output logic                     auto_mute_left_q,
  output logic                     auto_mute_right_q,
  output logic                     analog_mute_left_q,
  output logic                     analog_mute_right_q
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] zero_run_time_select_q;
  logic [7:0] mute_coupling_and_enables_q;
  logic [7:0] analog_mute_wait_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      zero_run_time_select_q      <= aamc_pkg::RST_ZERO_RUN_TIME_SELECT;
      mute_coupling_and_enables_q <= aamc_pkg::RST_MUTE_COUPLING_AND_ENABLES;
      analog_mute_wait_q          <= aamc_pkg::RST_ANALOG_MUTE_WAIT;
    end else if (reg_we) begin
      case (reg_addr)
        aamc_pkg::ADDR_ZERO_RUN_TIME_SELECT: begin
          zero_run_time_select_q <= reg_wdata & aamc_pkg::ZERO_RUN_TIME_MASK;
        end
        aamc_pkg::ADDR_MUTE_COUPLING_AND_ENABLES: begin
          mute_coupling_and_enables_q <= reg_wdata & aamc_pkg::COUPLING_MASK;
        end
        aamc_pkg::ADDR_ANALOG_MUTE_WAIT: begin
          analog_mute_wait_q <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // unmapped reads answer zero so software sees a defined value
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_re;
      if (reg_re) begin
        case (reg_addr)
          aamc_pkg::ADDR_ZERO_RUN_TIME_SELECT: begin
            reg_rdata_q <= zero_run_time_select_q;
          end
          aamc_pkg::ADDR_MUTE_COUPLING_AND_ENABLES: begin
            reg_rdata_q <= mute_coupling_and_enables_q;
          end
          aamc_pkg::ADDR_ANALOG_MUTE_WAIT: begin
            reg_rdata_q <= analog_mute_wait_q;
          end
          default: begin
            reg_rdata_q <= 8'h00;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic [2:0] left_zero_run_time;
  logic [2:0] right_zero_run_time;
  logic       mute_coupling_select;
  logic       mute_enable_bit1;
  logic       mute_enable_bit0;

  assign left_zero_run_time  = zero_run_time_select_q[
    aamc_pkg::LEFT_TIME_LSB +: aamc_pkg::TIME_W];
  assign right_zero_run_time = zero_run_time_select_q[
    aamc_pkg::RIGHT_TIME_LSB +: aamc_pkg::TIME_W];
  assign mute_coupling_select =
    mute_coupling_and_enables_q[aamc_pkg::COUPLING_BIT];
  assign mute_enable_bit1 =
    mute_coupling_and_enables_q[aamc_pkg::ENABLE_RIGHT_BIT];
  assign mute_enable_bit0 =
    mute_coupling_and_enables_q[aamc_pkg::ENABLE_LEFT_BIT];

  // ----------------------------------------------------------------
  // mute decision
  // ----------------------------------------------------------------
  logic [1:0] zero_met;
  logic [1:0] enable;
  logic [1:0] single;
  logic       joint;
  logic [1:0] mute_req;
  logic [1:0] muted;
  logic [1:0] analog_mute;
  logic [2:0] time_sel [2];
  logic [SAMPLE_W-1:0] samples [2];

  // index 0 is left, 1 is right
  assign enable      = {mute_enable_bit1, mute_enable_bit0};
  assign time_sel[0] = left_zero_run_time;
  assign time_sel[1] = right_zero_run_time;
  assign samples[0]  = sample_left;
  assign samples[1]  = sample_right;

  assign single = enable & zero_met;
  assign joint  = &single;
  assign mute_req = mute_coupling_select ? {joint, joint} : single;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    aamc_chan #(
      .SAMPLE_W (SAMPLE_W)
    ) u_chan (
      .clk_sys       (clk_sys),
      .resetn        (resetn),
      .frame_tick    (frame_tick),
      .sample        (samples[ch]),
      .time_sel      (time_sel[ch]),
      .mute_req      (mute_req[ch]),
      .wait_count    (analog_mute_wait_q),
      .zero_met      (zero_met[ch]),
      .muted_q       (muted[ch]),
      .analog_mute_q (analog_mute[ch])
    );
  end

  assign auto_mute_left_q    = muted[0];
  assign auto_mute_right_q   = muted[1];
  assign analog_mute_left_q  = analog_mute[0];
  assign analog_mute_right_q = analog_mute[1];

endmodule // aamc_top

// ### dv/aamc_monitor.sv
/* port assertions for the auto mute controller.
   assumes one clk_sys domain and reserved bits written as 0. */
`timescale 1ns/10ps
module aamc_monitor #(
  parameter int SAMPLE_W = 24
) (
  input wire logic                clk_sys,
  input wire logic                resetn,
  input wire logic                frame_tick,
  input wire logic [SAMPLE_W-1:0] sample_left,
  input wire logic [SAMPLE_W-1:0] sample_right,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_we,
  input wire logic                reg_re,
  input wire logic [7:0]          reg_rdata_q,
  input wire logic                reg_rvalid_q,
  input wire logic                auto_mute_left_q,
  input wire logic                auto_mute_right_q,
  input wire logic                analog_mute_left_q,
  input wire logic                analog_mute_right_q
);
  // --------
  // shadow settings and wait counters
  // --------
  logic [2:0] cfg_q;
  logic [7:0] w_q;
  logic [7:0] cl_q;
  logic [7:0] cr_q;
  logic       xl;
  logic       xr;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= 3'h4;
      w_q   <= 8'h14;
    end else if (reg_we && reg_addr == 8'h41) begin
      cfg_q <= reg_wdata[2:0];
    end else if (reg_we && reg_addr == 8'h42) begin
      w_q <= reg_wdata;
    end
  end
  // stops at the programmed wait, so raising it mid-mute resumes counting from the held count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cl_q <= 8'h00;
      cr_q <= 8'h00;
    end else begin
      if (!auto_mute_left_q) cl_q <= 8'h00;
      else if (frame_tick && cl_q < w_q) cl_q <= cl_q + 8'h01;
      if (!auto_mute_right_q) cr_q <= 8'h00;
      else if (frame_tick && cr_q < w_q) cr_q <= cr_q + 8'h01;
    end
  end
  assign xl = auto_mute_left_q && cl_q >= w_q;
  assign xr = auto_mute_right_q && cr_q >= w_q;
  // --------
  // assertions
  // --------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_live_l; frame_tick && sample_left != '0; endsequence
  sequence s_live_r; frame_tick && sample_right != '0; endsequence
  a_wait_readback:
    assert property (reg_re && reg_addr == 8'h42 |=>
      reg_rvalid_q && reg_rdata_q == $past(w_q))
    else $error("wait register read back wrong");
  a_coupling_readback:
    assert property (reg_re && reg_addr == 8'h41 |=>
      reg_rvalid_q && reg_rdata_q == {5'h00, $past(cfg_q)})
    else $error("coupling register read back wrong");
  a_left_release:
    assert property (s_live_l |-> ##2 !auto_mute_left_q)
    else $error("left mute held after live sample");
  a_right_release:
    assert property (s_live_r |-> ##2 !auto_mute_right_q)
    else $error("right mute held after live sample");
  a_left_enable:
    assert property (auto_mute_left_q |-> $past(cfg_q[0]))
    else $error("left muted while disabled");
  a_right_enable:
    assert property (auto_mute_right_q |-> $past(cfg_q[1]))
    else $error("right muted while disabled");
  a_coupled_equal:
    assert property ($past(cfg_q[2]) |->
      auto_mute_left_q == auto_mute_right_q)
    else $error("coupled channels muted apart");
  a_left_analog:
    assert property (analog_mute_left_q == $past(xl))
    else $error("left analog mute timing wrong");
  a_right_analog:
    assert property (analog_mute_right_q == $past(xr))
    else $error("right analog mute timing wrong");
endmodule // aamc_monitor

// ### dv/aamc_src_model.sv
/* audio frame source: one frame per cycle while go is high.
   assumes go and the zero selects change just after clk_sys rises. */
`timescale 1ns/10ps
module aamc_src_model #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                clk_sys,
  input  wire logic                go,
  input  wire logic                zero_l,
  input  wire logic                zero_r,
  output logic                     frame_tick,
  output logic      [SAMPLE_W-1:0] sample_left,
  output logic      [SAMPLE_W-1:0] sample_right
);
  localparam logic [SAMPLE_W-1:0] LSB = {{(SAMPLE_W-1){1'b0}}, 1'b1};
  // lines outside frames change every cycle, never a stale value
  logic [SAMPLE_W-1:0] pat_q = '1;
  always @(posedge clk_sys) pat_q <= pat_q + LSB;
  assign frame_tick   = go;
  assign sample_left  = !go ? pat_q : (zero_l ? '0 : pat_q | LSB);
  assign sample_right = !go ? ~pat_q : (zero_r ? '0 : pat_q | LSB);
endmodule // aamc_src_model

// ### dv/testbench.sv
/* self-checking bench for the auto mute controller.
   assumes the source model and the checker are compiled first. */
`timescale 1ns/10ps
module testbench;
  localparam int SW = 24;
  logic          clk_sys, resetn, go, zl, zr, we, re, tick;
  logic          rvalid, aml, amr, anl, anr;
  logic [7:0]    addr, wdata, rdata;
  logic [SW-1:0] sl, sr;
  int            n_errors, n_compared;
  aamc_src_model #(.SAMPLE_W(SW)) aamc_src_model_i (
    .clk_sys(clk_sys), .go(go), .zero_l(zl), .zero_r(zr),
    .frame_tick(tick), .sample_left(sl), .sample_right(sr));
  aamc_top #(.SAMPLE_W(SW)) aamc_top_i (
    .clk_sys(clk_sys), .resetn(resetn), .frame_tick(tick),
    .sample_left(sl), .sample_right(sr), .reg_addr(addr),
    .reg_wdata(wdata), .reg_we(we), .reg_re(re),
    .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
    .auto_mute_left_q(aml), .auto_mute_right_q(amr),
    .analog_mute_left_q(anl), .analog_mute_right_q(anr));
  // --------
  // tasks
  // --------
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // mute outputs as left, right, analog left, analog right
  task ms(input logic [3:0] e);
    chk({4'h0, aml, amr, anl, anr}, {4'h0, e});
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr = a; wdata = d; we = 1'b1;
    step;
    we = 1'b0;
    step;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    addr = a; re = 1'b1;
    step;
    re = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
    step;
  endtask
  task frames(input int n, input logic l, input logic r);
    zl = l; zr = r; go = 1'b1;
    repeat (n) step;
    go = 1'b0;
  endtask
  task summarize;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // --------
  // stimulus
  // --------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    summarize;
  end
  initial begin
    resetn = 1'b0; go = 1'b0; zl = 1'b1; zr = 1'b1;
    we = 1'b0; re = 1'b0; addr = 8'h00; wdata = 8'h00;
    n_errors = 0; n_compared = 0;
    repeat (5) @(posedge clk_sys);
    #1 resetn = 1'b1;
    rd(8'h3B, 8'h00);
    rd(8'h41, 8'h04);
    rd(8'h42, 8'h14);
    rd(8'h10, 8'h00);
    wr(8'h41, 8'h01);
    wr(8'h42, 8'h00);
    frames(1024, 1'b1, 1'b1);
    ms(4'h0);
    step;
    ms(4'h8);
    step;
    ms(4'hA);
    frames(1, 1'b0, 1'b0);
    step;
    ms(4'h2);
    step;
    ms(4'h0);
    wr(8'h3B, 8'h01);
    wr(8'h41, 8'h03);
    frames(1024, 1'b1, 1'b1);
    step;
    ms(4'h8);
    frames(4095, 1'b1, 1'b1);
    step;
    ms(4'hA);
    frames(1, 1'b1, 1'b1);
    step;
    ms(4'hE);
    wr(8'h3B, 8'h00);
    wr(8'h41, 8'h07);
    frames(1100, 1'b1, 1'b0);
    step;
    ms(4'h0);
    frames(1024, 1'b1, 1'b1);
    step;
    ms(4'hC);
    wr(8'h41, 8'h06);
    ms(4'h3);
    wr(8'h41, 8'h05);
    ms(4'h0);
    wr(8'h42, 8'h03);
    wr(8'h41, 8'h01);
    ms(4'h8);
    step;
    ms(4'h8);
    frames(2, 1'b1, 1'b1);
    step;
    ms(4'h8);
    frames(1, 1'b1, 1'b1);
    step;
    ms(4'hA);
    // mid-run reset: mutes drop, registers and run counts restart
    resetn = 1'b0;
    step;
    ms(4'h0);
    resetn = 1'b1;
    rd(8'h41, 8'h04);
    rd(8'h42, 8'h14);
    wr(8'h41, 8'h01);
    ms(4'h0);
    summarize;
  end
endmodule // testbench
bind aamc_top aamc_monitor #(.SAMPLE_W(SAMPLE_W)) aamc_monitor_i (
  .clk_sys(clk_sys), .resetn(resetn), .frame_tick(frame_tick),
  .sample_left(sample_left), .sample_right(sample_right),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .auto_mute_left_q(auto_mute_left_q),
  .auto_mute_right_q(auto_mute_right_q),
  .analog_mute_left_q(analog_mute_left_q),
  .analog_mute_right_q(analog_mute_right_q));
